// *** core/olf_pkg.sv ***
`default_nettype none
package olf_pkg;
  // Flag register layout
  localparam int FLAGS_W      = 32;
  localparam int BIT_CARRY    = 0;
  localparam int BIT_RSVD1    = 1;
  localparam int BIT_IO_PRIVILEGE_FIELD_LO  = 12;
  localparam int BIT_IO_PRIVILEGE_FIELD_HI  = 13;
  localparam int BIT_NT       = 14;
  localparam int BIT_RSVD15   = 15;
  localparam int BIT_AC       = 18;
  localparam int BIT_VIF      = 19;
  localparam int BIT_VIP      = 20;
  localparam int BIT_ID       = 21;
  // Writable bits of the flag register with all extensions present
  localparam logic [31:0] FLAGS_BASE_MASK  = 32'h003C7FD5;
  localparam logic [31:0] FLAGS_FIXED_ONES = 32'h00000002;
  localparam logic [31:0] FLAGS_RESET      = 32'h00000002;
  // Feature word bit positions
  localparam int FEAT_FPU    = 0;
  localparam int FEAT_TSC    = 4;
  localparam int FEAT_MSR    = 5;
  localparam int FEAT_CX8    = 8;
  localparam int FEAT_CMOV   = 15;
  // Opcode classes presented to the decoder
  typedef enum logic [3:0] {
    OLF_OP_PLAIN,
    OLF_OP_RESERVED,
    OLF_OP_TESTREG_RD,
    OLF_OP_TESTREG_WR,
    OLF_OP_FP_CMP_FLAGS,
    OLF_OP_CMPXCHG8,
    OLF_OP_READ_TS,
    OLF_OP_READ_MODEL,
    OLF_OP_WRITE_MODEL,
    OLF_OP_IDENT,
    OLF_OP_COND_MOVE
  } olf_op_t;
  typedef enum logic [1:0] {
    OLF_ST_IDLE,
    OLF_ST_FAULT
  } olf_state_t;
endpackage : olf_pkg
`default_nettype wire

// *** core/olf_feat_gate.sv ***
`default_nettype none
module olf_feat_gate
  import olf_pkg::*;
#(
  parameter int NBITS = 2
)
(
  // Feature lookup
  input  wire logic [31:0]    feat_i,
  input  wire logic [NBITS*5-1:0] pos_i,
  output logic                ok_o
);
  // Refused at elaboration; an empty list would always pass
  if (NBITS < 1)
  begin : g_bad_nbits
    $error("olf_feat_gate: NBITS must be at least 1");
  end
  // All listed feature bits must be set together
  always_comb
  begin
    ok_o = 1'b1;
    for (int k = 0; k < NBITS; k++)
    begin
      ok_o = ok_o & feat_i[pos_i[k*5 +: 5]];
    end
  end
endmodule : olf_feat_gate
`default_nettype wire

// *** core/olf_core.sv ***
`default_nettype none
// How it works
// - Reserved encodings raise invalid-opcode and change nothing else.
// - Test-register moves, either direction, raise invalid-opcode.
// - Flags hold virtual interrupt at 19, pending at 20, ident at 21.
// - Alignment-check flag at bit 18 is software writable.
// - Ident bit 21 sets and clears freely, showing ident instruction exists.
// - Without virtual mode extensions, bits 19 and 20 read zero.
// - Pushing the stack pointer stores its value before decrement.
// - Real-mode flag pushes store bit 15 zero, bits 12-14 as loaded.
// - Floating compare-to-flags reported through feature bits 0 and 15.
// - Eight-byte compare-exchange reported through feature bit 8.
// - Timestamp read reported through feature bit 4.
// - Model register read and write both reported through bit 5.
// - Changing a reserved control bit raises general-protection.
module olf_core
  import olf_pkg::*;
#(
  parameter bit          HAS_VME   = 1'b1,
  parameter bit          HAS_FPU   = 1'b1,
  parameter bit          HAS_CMOV  = 1'b1,
  parameter bit          HAS_CX8   = 1'b1,
  parameter bit          HAS_TSC   = 1'b1,
  parameter bit          HAS_MSR   = 1'b1,
  parameter int          CTRL_W    = 32,
  parameter logic [31:0] CTRL_RSVD = 32'hFFFFF800
)
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CE_I,
  // Instruction presented for execution
  input  wire logic              OP_VALID_I,
  input  wire olf_op_t           OP_CLASS_I,
  // Flag register load
  input  wire logic              FLAGS_WR_I,
  input  wire logic [31:0]       FLAGS_WDATA_I,
  // Flag push request
  input  wire logic              FLAGS_PUSH_I,
  input  wire logic              REAL_MODE_I,
  // Stack pointer push
  input  wire logic              SP_PUSH_I,
  input  wire logic [31:0]       SP_I,
  input  wire logic [2:0]        PUSH_SIZE_I,
  // Control register write
  input  wire logic              CTRL_WR_I,
  input  wire logic [CTRL_W-1:0] CTRL_WDATA_I,
  // Results
  output logic [31:0]            FLAGS_O,
  output logic [31:0]            FEATURES_O,
  output logic                   UD_O,
  output logic                   GP_O,
  output logic                   OP_EXEC_O,
  output logic [CTRL_W-1:0]      CTRL_O,
  output logic                   PUSH_VALID_O,
  output logic [31:0]            PUSH_DATA_O,
  output logic [31:0]            SP_O,
  output logic                   FAULT_BUSY_O
);
  // Control word wider than the reserved mask cannot be checked
  if (CTRL_W < 1 || CTRL_W > FLAGS_W)
  begin : g_bad_ctrl_w
    $error("olf_core: CTRL_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature word and writable masks

  logic [31:0] feat;
  logic [31:0] wr_mask;
  logic [31:0] vme_bits;

  // Compile-time feature word; unused positions stay zero
  always_comb
  begin
    feat            = 32'h00000000;
    feat[FEAT_FPU]  = HAS_FPU;
    feat[FEAT_CMOV] = HAS_CMOV;
    feat[FEAT_CX8]  = HAS_CX8;
    feat[FEAT_TSC]  = HAS_TSC;
    feat[FEAT_MSR]  = HAS_MSR;
  end

  // Virtual bits drop out of the mask when extensions are absent
  always_comb
  begin
    vme_bits          = 32'h00000000;
    vme_bits[BIT_VIF] = 1'b1;
    vme_bits[BIT_VIP] = 1'b1;
    wr_mask           = FLAGS_BASE_MASK;
    if (!HAS_VME)
    begin
      wr_mask = wr_mask & ~vme_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Opcode legality

  logic fcmp_ok;
  logic msr_ok;

  // Shared gate checks multi-bit feature reporting
  olf_feat_gate #(.NBITS(2)) u_fcmp_gate
  (
    .feat_i (feat),
    .pos_i  ({5'(FEAT_CMOV), 5'(FEAT_FPU)}),
    .ok_o   (fcmp_ok)
  );

  olf_feat_gate #(.NBITS(1)) u_msr_gate
  (
    .feat_i (feat),
    .pos_i  (5'(FEAT_MSR)),
    .ok_o   (msr_ok)
  );

  logic illegal;

  // Classify the presented instruction
  always_comb
  begin
    case (OP_CLASS_I)
      OLF_OP_PLAIN:        illegal = 1'b0;
      OLF_OP_IDENT:        illegal = 1'b0;
      OLF_OP_RESERVED:     illegal = 1'b1;
      OLF_OP_TESTREG_RD:   illegal = 1'b1;
      OLF_OP_TESTREG_WR:   illegal = 1'b1;
      OLF_OP_FP_CMP_FLAGS: illegal = !fcmp_ok;
      OLF_OP_CMPXCHG8:     illegal = !feat[FEAT_CX8];
      OLF_OP_READ_TS:      illegal = !feat[FEAT_TSC];
      OLF_OP_READ_MODEL:   illegal = !msr_ok;
      OLF_OP_WRITE_MODEL:  illegal = !msr_ok;
      OLF_OP_COND_MOVE:    illegal = !feat[FEAT_CMOV];
      default:             illegal = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault state; a fault holds one cycle then returns to idle

  logic              gp_now;
  logic [CTRL_W-1:0] rsvd_mask;

  // Any reserved bit that differs from the held value faults
  // Compared with the held value, so rewriting what was read is safe
  assign rsvd_mask = CTRL_RSVD[CTRL_W-1:0];
  assign gp_now    = CTRL_WR_I &&
                     (((CTRL_WDATA_I ^ CTRL_O) & rsvd_mask) != '0);

  olf_state_t state_q;
  olf_state_t state_d;

  // Next state from this cycle's faults
  always_comb
  begin
    state_d = OLF_ST_IDLE;
    case (state_q)
      OLF_ST_IDLE:
      begin
        if ((OP_VALID_I && illegal) || gp_now)
        begin
          state_d = OLF_ST_FAULT;
        end
      end
      OLF_ST_FAULT: state_d = OLF_ST_IDLE;
      default:      state_d = OLF_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      state_q <= OLF_ST_IDLE;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
    end
  end

  // Exception outputs registered one cycle after the request
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      UD_O      <= 1'b0;
      GP_O      <= 1'b0;
      OP_EXEC_O <= 1'b0;
    end
    else if (CE_I)
    begin
      UD_O      <= OP_VALID_I && illegal;
      GP_O      <= gp_now;
      OP_EXEC_O <= OP_VALID_I && !illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a faulting write leaves it untouched

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      CTRL_O <= '0;
    end
    else if (CE_I && CTRL_WR_I && !gp_now)
    begin
      CTRL_O <= CTRL_WDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register

  // Only mapped bits take writes; fixed ones forced back in
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      FLAGS_O <= FLAGS_RESET;
    end
    else if (CE_I && FLAGS_WR_I)
    begin
      FLAGS_O <= (FLAGS_WDATA_I & wr_mask) | FLAGS_FIXED_ONES;
    end
  end

  // Feature word held in a flop so it is a clean data output
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      FEATURES_O <= 32'h00000000;
    end
    else if (CE_I)
    begin
      FEATURES_O <= feat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pushes

  logic [31:0] flag_img;

  // Real mode stores reserved bit 15 cleared, 12-14 as last loaded
  // A load in the same cycle is not seen: the image is the held value
  always_comb
  begin
    flag_img = FLAGS_O;
    if (REAL_MODE_I)
    begin
      flag_img[BIT_RSVD15] = 1'b0;
    end
  end

  // Stack pointer push stores pre-decrement value; flag push wins
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      PUSH_VALID_O <= 1'b0;
      PUSH_DATA_O  <= 32'h00000000;
    end
    else if (CE_I)
    begin
      PUSH_VALID_O <= FLAGS_PUSH_I || SP_PUSH_I;
      if (FLAGS_PUSH_I)
      begin
        PUSH_DATA_O <= flag_img;
      end
      else if (SP_PUSH_I)
      begin
        PUSH_DATA_O <= SP_I;
      end
    end
  end

  // New stack pointer only moves on a pointer push that the flag push
  // did not override, so a lost push leaves the pointer where it was
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      SP_O <= 32'h00000000;
    end
    else if (CE_I && SP_PUSH_I && !FLAGS_PUSH_I)
    begin
      SP_O <= SP_I - {29'h00000000, PUSH_SIZE_I};
    end
  end

  // Busy while the fault state is held
  assign FAULT_BUSY_O = (state_q == OLF_ST_FAULT);
endmodule : olf_core
`default_nettype wire

// *** sim/olf_core_chk.sv ***
`default_nettype none
module olf_core_chk
  import olf_pkg::*;
#(
  parameter bit          HAS_VME   = 1'b1,
  parameter bit          HAS_FPU   = 1'b1,
  parameter bit          HAS_CMOV  = 1'b1,
  parameter bit          HAS_CX8   = 1'b1,
  parameter bit          HAS_TSC   = 1'b1,
  parameter bit          HAS_MSR   = 1'b1,
  parameter int          CTRL_W    = 32,
  parameter logic [31:0] CTRL_RSVD = 32'hFFFFF800
)
(
  // Clock and reset
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              CE_I,
  // Requests
  input wire logic              OP_VALID_I,
  input wire olf_op_t           OP_CLASS_I,
  input wire logic              FLAGS_WR_I,
  input wire logic [31:0]       FLAGS_WDATA_I,
  input wire logic              FLAGS_PUSH_I,
  input wire logic              REAL_MODE_I,
  input wire logic              SP_PUSH_I,
  input wire logic [31:0]       SP_I,
  input wire logic              CTRL_WR_I,
  input wire logic [CTRL_W-1:0] CTRL_WDATA_I,
  // Results
  input wire logic [31:0]       FLAGS_O,
  input wire logic [31:0]       FEATURES_O,
  input wire logic              UD_O,
  input wire logic              GP_O,
  input wire logic              OP_EXEC_O,
  input wire logic [CTRL_W-1:0] CTRL_O,
  input wire logic              PUSH_VALID_O,
  input wire logic [31:0]       PUSH_DATA_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  //////////////////////////////////////////////////////////////////////////
  // Illegal encodings fault; a reserved encoding must also leave the flags untouched
  AST_UD_RESERVED: assert property (
    CE_I && OP_VALID_I && !FLAGS_WR_I && OP_CLASS_I == OLF_OP_RESERVED
    |=> UD_O && !OP_EXEC_O && $stable(FLAGS_O)) else $error("reserved op");
  AST_UD_TESTREG: assert property (
    CE_I && OP_VALID_I
    && OP_CLASS_I inside {OLF_OP_TESTREG_RD, OLF_OP_TESTREG_WR}
    |=> UD_O && !OP_EXEC_O) else $error("test register move");
  // Writable upper flag bits follow the loaded data
  AST_AC_WRITE: assert property (
    CE_I && FLAGS_WR_I |=> FLAGS_O[18] == $past(FLAGS_WDATA_I[18]))
    else $error("align check bit");
  AST_ID_WRITE: assert property (
    CE_I && FLAGS_WR_I |=> FLAGS_O[21] == $past(FLAGS_WDATA_I[21]))
    else $error("ident bit");
  AST_VIRT_BITS: assert property (
    CE_I && FLAGS_WR_I
    |=> FLAGS_O[20:19] == ($past(FLAGS_WDATA_I[20:19]) & {2{HAS_VME}}))
    else $error("virtual bits");
  // Fixed bits never move, whatever is written
  AST_FIXED_BITS: assert property (
    (FLAGS_O & 32'hFFC3802A) == 32'h00000002) else $error("fixed bits");
  // Pushes store the pre-decrement pointer or the real-mode image
  AST_SP_PUSH: assert property (
    CE_I && SP_PUSH_I && !FLAGS_PUSH_I
    |=> PUSH_VALID_O && PUSH_DATA_O == $past(SP_I)) else $error("sp push");
  AST_REAL_PUSH: assert property (
    CE_I && FLAGS_PUSH_I && REAL_MODE_I && !FLAGS_WR_I
    |=> PUSH_VALID_O && !PUSH_DATA_O[15]
    && PUSH_DATA_O[14:12] == $past(FLAGS_O[14:12])) else $error("flag push");
  // Feature word settles one edge after reset
  AST_FEATURES: assert property (
    $past(RESET_N_I) |-> {FEATURES_O[15], FEATURES_O[8], FEATURES_O[5:4],
    FEATURES_O[0]} == {HAS_CMOV, HAS_CX8, HAS_MSR, HAS_TSC, HAS_FPU})
    else $error("feature word");
  AST_CTRL_GP: assert property (
    CE_I && CTRL_WR_I && ((CTRL_WDATA_I ^ CTRL_O) & CTRL_RSVD[CTRL_W-1:0]) != 0
    |=> GP_O && $stable(CTRL_O)) else $error("reserved ctrl bit");
  // Main scenarios reached
  COV_UD: cover property (UD_O);
  COV_GP: cover property (GP_O);
  COV_PUSH: cover property (FLAGS_PUSH_I && REAL_MODE_I ##1 PUSH_VALID_O);
endmodule : olf_core_chk
bind olf_core olf_core_chk #(.HAS_VME(HAS_VME), .HAS_FPU(HAS_FPU),
  .HAS_CMOV(HAS_CMOV), .HAS_CX8(HAS_CX8), .HAS_TSC(HAS_TSC),
  .HAS_MSR(HAS_MSR), .CTRL_W(CTRL_W), .CTRL_RSVD(CTRL_RSVD)) chk_u (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
  .OP_VALID_I(OP_VALID_I), .OP_CLASS_I(OP_CLASS_I),
  .FLAGS_WR_I(FLAGS_WR_I), .FLAGS_WDATA_I(FLAGS_WDATA_I),
  .FLAGS_PUSH_I(FLAGS_PUSH_I), .REAL_MODE_I(REAL_MODE_I),
  .SP_PUSH_I(SP_PUSH_I), .SP_I(SP_I), .CTRL_WR_I(CTRL_WR_I),
  .CTRL_WDATA_I(CTRL_WDATA_I), .FLAGS_O(FLAGS_O), .FEATURES_O(FEATURES_O),
  .UD_O(UD_O), .GP_O(GP_O), .OP_EXEC_O(OP_EXEC_O), .CTRL_O(CTRL_O),
  .PUSH_VALID_O(PUSH_VALID_O), .PUSH_DATA_O(PUSH_DATA_O));
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top
  import olf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, ce, op_valid, flags_wr, flags_push, real_mode;
  logic        sp_push, ctrl_wr, ud, gp, op_exec, push_valid, fault_busy;
  olf_op_t     op_class;
  logic [31:0] flags_wdata, sp, ctrl_wdata, flags, features, ctrl;
  logic [31:0] push_data, sp_new;
  logic [2:0]  push_size;
  logic [31:0] flags_b, features_b;
  logic        ud_b, exec_b;
  int          num_errors, samples_checked;
  //////////////////////////////////////////////////////////////////////////
  olf_core dut_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .OP_VALID_I(op_valid),
    .OP_CLASS_I(op_class), .FLAGS_WR_I(flags_wr), .FLAGS_WDATA_I(flags_wdata),
    .FLAGS_PUSH_I(flags_push), .REAL_MODE_I(real_mode), .SP_PUSH_I(sp_push),
    .SP_I(sp), .PUSH_SIZE_I(push_size), .CTRL_WR_I(ctrl_wr),
    .CTRL_WDATA_I(ctrl_wdata), .FLAGS_O(flags), .FEATURES_O(features),
    .UD_O(ud), .GP_O(gp), .OP_EXEC_O(op_exec), .CTRL_O(ctrl),
    .PUSH_VALID_O(push_valid), .PUSH_DATA_O(push_data), .SP_O(sp_new),
    .FAULT_BUSY_O(fault_busy));
  // Lean build: no optional feature, no virtual mode extensions
  olf_core #(.HAS_VME(1'b0), .HAS_FPU(1'b0), .HAS_CMOV(1'b0),
    .HAS_CX8(1'b0), .HAS_TSC(1'b0), .HAS_MSR(1'b0)) dut_lean_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .OP_VALID_I(op_valid),
    .OP_CLASS_I(op_class), .FLAGS_WR_I(flags_wr), .FLAGS_WDATA_I(flags_wdata),
    .FLAGS_PUSH_I(flags_push), .REAL_MODE_I(real_mode), .SP_PUSH_I(sp_push),
    .SP_I(sp), .PUSH_SIZE_I(push_size), .CTRL_WR_I(ctrl_wr),
    .CTRL_WDATA_I(ctrl_wdata), .FLAGS_O(flags_b), .FEATURES_O(features_b),
    .UD_O(ud_b), .GP_O(), .OP_EXEC_O(exec_b), .CTRL_O(), .PUSH_VALID_O(),
    .PUSH_DATA_O(), .SP_O(), .FAULT_BUSY_O());
  // 25 MHz core clock
  always #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // One instruction; a fault must never also execute
  task op(input olf_op_t c, input logic bad, input logic bad_b);
    @(posedge clk);
    op_class <= c;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    check("ud", ud, bad);
    check("exec", op_exec, !bad);
    check("busy", fault_busy, bad);
    check("ud_lean", ud_b, bad_b);
    check("exec_lean", exec_b, !bad_b);
  endtask : op
  task wflags(input logic [31:0] d);
    @(posedge clk);
    flags_wdata <= d;
    flags_wr    <= 1'b1;
    @(posedge clk);
    flags_wr <= 1'b0;
    #1;
  endtask : wflags
  task wctrl(input logic [31:0] d);
    @(posedge clk);
    ctrl_wdata <= d;
    ctrl_wr    <= 1'b1;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask : wctrl
  task push(input logic f, input logic s);
    @(posedge clk);
    flags_push <= f;
    sp_push    <= s;
    @(posedge clk);
    flags_push <= 1'b0;
    sp_push    <= 1'b0;
    #1;
    check("push_valid", push_valid, 1'b1);
  endtask : push
  //////////////////////////////////////////////////////////////////////////
  // Hang guard: far above the run length
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report;
  end
  // Main sequence
  initial
  begin
    {clk, op_valid, flags_wr, flags_push, sp_push, ctrl_wr} = '0;
    {rst_n, ce, real_mode} = 3'b011;
    op_class = OLF_OP_PLAIN;
    {flags_wdata, ctrl_wdata} = '0;
    sp = 32'h00000100;
    push_size = 3'h4;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("flags_rst", flags, FLAGS_RESET);
    op(OLF_OP_RESERVED, 1'b1, 1'b1);
    op(OLF_OP_TESTREG_RD, 1'b1, 1'b1);
    op(OLF_OP_TESTREG_WR, 1'b1, 1'b1);
    for (int i = 4; i <= 10; i++)
      op(olf_op_t'(i), 1'b0, olf_op_t'(i) != OLF_OP_IDENT);
    check("feat_lean", features_b, 32'h00000000);
    check("fp_cmp", {features[15], features[0]}, 2'h3);
    check("cx8", features[8], 1'b1);
    check("tsc", features[4], 1'b1);
    check("msr", features[5], 1'b1);
    wflags(32'hFFFFFFFF);
    check("flags_hi", flags[21:18], 4'hF);
    check("flags_fix", flags & 32'hFFC3802A, 32'h00000002);
    check("flags_lean", flags_b[21:18], 4'h9);
    // Fault right after a load must leave the loaded bits alone
    op(OLF_OP_RESERVED, 1'b1, 1'b1);
    check("flags_keep", flags[21:18], 4'hF);
    push(1'b1, 1'b0);
    check("push_flags", push_data[15:12], 4'h7);
    wflags(32'h00000000);
    check("flags_lo", flags[21:18], 4'h0);
    // Clock enable low must freeze the flags through a load
    @(posedge clk);
    ce <= 1'b0;
    wflags(32'hFFFFFFFF);
    check("ce_hold", flags[21:18], 4'h0);
    @(posedge clk);
    ce <= 1'b1;
    push(1'b0, 1'b1);
    check("push_sp", push_data, 32'h00000100);
    check("sp_new", sp_new, 32'h000000FC);
    wctrl(32'h000007FF);
    check("gp_ok", gp, 1'b0);
    check("ctrl", ctrl, 32'h000007FF);
    wctrl(32'h00000FFF);
    check("gp", gp, 1'b1);
    check("ctrl_keep", ctrl, 32'h000007FF);
    final_report;
  end
endmodule : tb_top
`default_nettype wire
